// ### rlt_consts.svh
`ifndef RLT_CONSTS_SVH
`define RLT_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Single-rate read opcodes, 3-byte and 4-byte address forms
`define RLT_OP_READ3      8'h03
`define RLT_OP_READ4      8'h13
`define RLT_OP_FAST3      8'h0b
`define RLT_OP_FAST4      8'h0c
`define RLT_OP_DOUT3      8'h3b
`define RLT_OP_DOUT4      8'h3c
`define RLT_OP_QOUT3      8'h6b
`define RLT_OP_QOUT4      8'h6c
`define RLT_OP_DIO3       8'hbb
`define RLT_OP_DIO4       8'hbc
`define RLT_OP_QIO3       8'heb
`define RLT_OP_QIO4       8'hec

// Double-data-rate read opcodes
`define RLT_OP_DDR_FAST3  8'h0d
`define RLT_OP_DDR_FAST4  8'h0e
`define RLT_OP_DDR_DIO3   8'hbd
`define RLT_OP_DDR_DIO4   8'hbe
`define RLT_OP_DDR_QIO3   8'hed
`define RLT_OP_DDR_QIO4   8'hee

////////////////////////////////////////////////////////////////////////////////
// Table entry meaning the command is not supported at this frequency
`define RLT_NA            8'hff
// Latency code of the two single-rate rows held here
`define RLT_SDR_CODE      2'b10
// Offset of the first cycle entry of row 0 in the DDR query parameter
`define RLT_DDR_ROW_BASE  6'h0e
// Number of bytes in the DDR query parameter (id, length and 2ah more)
`define RLT_QUERY_LEN     6'd44

// DDR query parameter bytes 00h..15h and 16h..2bh, first byte leftmost
`define RLT_DDR_QUERY_HI  176'h9a2a0508_46430d0e_bdbeedee_32030004_00040103_4200
`define RLT_DDR_QUERY_LO  176'h0005_00060106_42010006_00070107_42020007_00080108

// Single-rate rows: mode/latency pairs for read, fast, dual out,
// quad out, dual I/O and quad I/O, leftmost first
`define RLT_SDR_ROW104    96'hffff_0008_0008_0008_0006_0205
`define RLT_SDR_ROW133    96'hffff_0008_ffff_ffff_ffff_ffff

////////////////////////////////////////////////////////////////////////////////
// Command framing
`define RLT_CMD_LAST      8'd7
`define RLT_ADDR3_BITS    8'd24
`define RLT_ADDR4_BITS    8'd32
// Host clock cycles per half period of the serial clock
`define RLT_SCK_HALF      8

`endif

// ### rlt_device.sv
// Operation
// - 104 MHz single-rate row uses code 10
// - 104 MHz row: normal read not supported
// - 104 MHz: fast/dual/quad out 0+8
// - 104 MHz: dual I/O 0 mode, 6
// - 104 MHz: quad I/O 2 mode, 5
// - 133 MHz code 10: fast 0+8
// - 133 MHz: host avoids other reads
// - DDR parameter id 9Ah, length 2Ah, rows
// - Next parameter at length byte+1+length
// - DDR header bytes 46h and 43h
// - DDR fast read opcodes 0Dh, 0Eh
// - DDR dual I/O opcodes BDh, BEh
// - DDR quad I/O opcodes EDh, EEh
// - DDR 50 MHz code 11 latencies
// - DDR 66 MHz code 00 latencies
// - DDR 66 MHz code 01 latencies
// - DDR 66 MHz code 10 latencies
`timescale 1ns/1ps
`include "rlt_consts.svh"
`default_nettype none

module rlt_device
	import rlt_pkg::*;
(
	rlt_link_if.device        link,
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic [1:0]   lat_code,
	input  wire logic         fast_row,
	output logic              rd_active,
	output logic              cmd_refused
);

	////////////////////////////////////////////////////////////////////////////
	logic [1:0]     sck_sync_reg;
	logic [1:0]     cs_sync_reg;
	logic [3:0]     io_s1_reg;
	logic [3:0]     io_s2_reg;
	logic           sck_prev_reg;
	rlt_dstate_type state_reg;
	logic [7:0]     cnt_reg;
	logic [7:0]     op_reg;
	rlt_cmd_type    cmd_reg;
	logic [31:0]    addr_reg;
	logic [8:0]     wait_reg;
	logic [5:0]     idx_reg;
	logic [7:0]     sr_reg;
	logic [3:0]     left_reg;
	logic [3:0]     io_out_reg;
	logic [3:0]     io_oe_reg;
	logic           rd_active_reg;
	logic           refused_reg;

	logic           rise;
	logic           fall;
	logic           cs_hi;
	logic [7:0]     op_full;
	rlt_cmd_type    cmd_c;
	logic [15:0]    lat_c;
	logic           reject_c;
	logic           cmd_end_c;
	logic [2:0]     aw;
	logic [2:0]     dw;
	logic           addr_sample;
	logic           drive;
	logic [7:0]     cur_byte;

	////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for the link pins, plus the clock edge history
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sck_sync_reg <= 2'b00;
			cs_sync_reg  <= 2'b11;
			io_s1_reg    <= 4'h0;
			io_s2_reg    <= 4'h0;
			sck_prev_reg <= 1'b0;
		end else begin
			sck_sync_reg <= {sck_sync_reg[0], link.sck};
			cs_sync_reg  <= {cs_sync_reg[0], link.cs_n};
			io_s1_reg    <= link.io;
			io_s2_reg    <= io_s1_reg;
			sck_prev_reg <= sck_sync_reg[1];
		end
	end

	// Serial clock edges and frame state seen in the local domain
	assign rise  = sck_sync_reg[1] & ~sck_prev_reg;
	assign fall  = ~sck_sync_reg[1] & sck_prev_reg;
	assign cs_hi = cs_sync_reg[1];

	////////////////////////////////////////////////////////////////////////////
	// Command decode and latency row selection on the last opcode bit
	assign op_full   = {op_reg[6:0], io_s2_reg[0]};
	assign cmd_c     = rlt_decode(op_full);
	assign lat_c     = rlt_lat_lookup(cmd_c.ddr, fast_row, lat_code, cmd_c.kind);
	// Not-supported entries make the device ignore the rest of the frame
	assign reject_c  = !cmd_c.valid || lat_c[15:8] == `RLT_NA || lat_c[7:0] == `RLT_NA;
	assign cmd_end_c = !cs_hi && state_reg == RLT_D_CMD && rise && cnt_reg == `RLT_CMD_LAST;
	assign aw        = rlt_addr_width(cmd_reg.kind);
	assign dw        = rlt_data_width(cmd_reg.kind);
	// Address is taken on rising edges, or on both edges at double rate
	assign addr_sample = rise | (cmd_reg.ddr & fall);
	// Data leaves on falling edges, and on both edges at double rate
	assign drive     = fall | (cmd_reg.ddr & rise);
	assign cur_byte  = (left_reg == 4'd0) ? rlt_query_byte(idx_reg) : sr_reg;

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer: opcode, address, mode plus latency, then data
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= RLT_D_IDLE;
			cnt_reg   <= 8'h00;
			op_reg    <= 8'h00;
			cmd_reg   <= '0;
			addr_reg  <= 32'h0000_0000;
			wait_reg  <= 9'h000;
		end else if (cs_hi) begin
			state_reg <= RLT_D_IDLE;
		end else begin
			case (state_reg)
				RLT_D_IDLE: begin
					state_reg <= RLT_D_CMD;
					cnt_reg   <= 8'h00;
					addr_reg  <= 32'h0000_0000;
				end
				RLT_D_CMD: begin
					if (rise) begin
						op_reg  <= op_full;
						cnt_reg <= cnt_reg + 8'd1;
					end
					if (cmd_end_c && reject_c) begin
						state_reg <= RLT_D_IGNORE;
					end else if (cmd_end_c) begin
						state_reg <= RLT_D_ADDR;
						cmd_reg   <= cmd_c;
						cnt_reg   <= cmd_c.addr4 ? `RLT_ADDR4_BITS : `RLT_ADDR3_BITS;
						// Cycles to insert: mode first, then latency
						wait_reg  <= {1'b0, lat_c[15:8]} + {1'b0, lat_c[7:0]};
					end
				end
				RLT_D_ADDR: begin
					if (addr_sample) begin
						addr_reg <= rlt_shift_in(addr_reg, io_s2_reg, aw);
						cnt_reg  <= cnt_reg - {5'h00, aw};
						if (cnt_reg == {5'h00, aw})
							state_reg <= RLT_D_WAIT;
					end
				end
				RLT_D_WAIT: begin
					// Mode bits from the host are not interpreted
					if (rise) begin
						wait_reg <= wait_reg - 9'd1;
						if (wait_reg <= 9'd1)
							state_reg <= RLT_D_DATA;
					end
				end
				RLT_D_DATA: state_reg <= RLT_D_DATA;
				RLT_D_IGNORE: state_reg <= RLT_D_IGNORE;
				default: state_reg <= RLT_D_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data shifter over the fixed DDR query parameter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			io_out_reg <= 4'h0;
			io_oe_reg  <= 4'h0;
			idx_reg    <= 6'h00;
			sr_reg     <= 8'h00;
			left_reg   <= 4'h0;
		end else if (cs_hi || state_reg != RLT_D_DATA) begin
			io_out_reg <= 4'h0;
			io_oe_reg  <= 4'h0;
			idx_reg    <= addr_reg[5:0];
			sr_reg     <= 8'h00;
			left_reg   <= 4'h0;
		end else if (drive) begin
			io_out_reg <= rlt_top_bits({cur_byte, 24'h00_0000}, dw);
			io_oe_reg  <= rlt_lane_mask(dw);
			sr_reg     <= 8'(cur_byte << dw);
			left_reg   <= ((left_reg == 4'd0) ? 4'd8 : left_reg) - {1'b0, dw};
			if (left_reg == 4'd0)
				idx_reg <= idx_reg + 6'd1; // Byte order as stored, wraps at 64
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// User-side status
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_active_reg <= 1'b0;
			refused_reg   <= 1'b0;
		end else begin
			rd_active_reg <= !cs_hi && state_reg == RLT_D_DATA;
			refused_reg   <= cmd_end_c && reject_c;
		end
	end

	assign link.d_io_out = io_out_reg;
	assign link.d_io_oe  = io_oe_reg;
	assign rd_active     = rd_active_reg;
	assign cmd_refused   = refused_reg;

endmodule

`default_nettype wire

// ### rlt_host.sv
`timescale 1ns/1ps
`include "rlt_consts.svh"
`default_nettype none

module rlt_host
	import rlt_pkg::*;
#(
	parameter int unsigned SCK_HALF = `RLT_SCK_HALF
) (
	rlt_link_if.host          link,
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic [7:0]   opcode,
	input  wire logic [31:0]  addr,
	input  wire logic [7:0]   byte_count,
	input  wire logic [1:0]   lat_code,
	input  wire logic         fast_row,
	output logic              busy,
	output logic [7:0]        rd_data,
	output logic              rd_valid,
	output logic              done,
	output logic              refused
);

	////////////////////////////////////////////////////////////////////////////
	rlt_hstate_type state_reg;
	rlt_cmd_type    cmd_reg;
	logic [7:0]     phase_reg;
	logic [7:0]     cnt_reg;
	logic [8:0]     wait_reg;
	logic [7:0]     lat_reg;
	logic [7:0]     op_sr_reg;
	logic [31:0]    addr_sr_reg;
	logic [31:0]    data_sr_reg;
	logic [3:0]     bit_reg;
	logic [7:0]     bytes_reg;
	logic           first_reg;
	logic           sck_reg;
	logic           cs_n_reg;
	logic [3:0]     io_out_reg;
	logic [3:0]     io_oe_reg;
	logic [3:0]     io_s1_reg;
	logic [3:0]     io_s2_reg;
	logic           busy_reg;
	logic [7:0]     rd_data_reg;
	logic           rd_valid_reg;
	logic           done_reg;
	logic           refused_reg;

	rlt_cmd_type    cmd_c;
	logic [15:0]    lat_c;
	logic           reject_c;
	logic           go_c;
	logic           mid_c;
	logic           edge_c;
	logic [2:0]     aw;
	logic [2:0]     dw;
	logic           sample_c;
	logic           byte_c;
	logic [31:0]    data_next;

	////////////////////////////////////////////////////////////////////////////
	// Request check: row lookup identical to the device's
	assign cmd_c    = rlt_decode(opcode);
	assign lat_c    = rlt_lat_lookup(cmd_c.ddr, fast_row, lat_code, cmd_c.kind);
	// Prohibited or unknown commands never reach the link
	assign reject_c = !cmd_c.valid || lat_c[15:8] == `RLT_NA || lat_c[7:0] == `RLT_NA;
	assign go_c     = state_reg == RLT_H_IDLE && start && !reject_c;
	assign mid_c    = phase_reg == 8'(SCK_HALF / 2 - 1);
	assign edge_c   = phase_reg == 8'(SCK_HALF - 1);
	assign aw       = rlt_addr_width(cmd_reg.kind);
	assign dw       = rlt_data_width(cmd_reg.kind);
	// Sample just before the edge that follows each device launch
	assign sample_c = state_reg == RLT_H_DATA && edge_c && (cmd_reg.ddr ? !first_reg : !sck_reg);
	assign byte_c   = sample_c && ({1'b0, bit_reg} + {2'b00, dw}) == 5'd8;
	assign data_next = rlt_shift_in(data_sr_reg, io_s2_reg, dw);

	////////////////////////////////////////////////////////////////////////////
	// Serial clock divider phase and read data synchroniser
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= 8'h00;
			io_s1_reg <= 4'h0;
			io_s2_reg <= 4'h0;
		end else begin
			phase_reg <= (state_reg == RLT_H_IDLE || edge_c) ? 8'h00 : phase_reg + 8'd1;
			io_s1_reg <= link.io;
			io_s2_reg <= io_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer, serial clock and chip select
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= RLT_H_IDLE;
			cmd_reg   <= '0;
			cnt_reg   <= 8'h00;
			wait_reg  <= 9'h000;
			lat_reg   <= 8'h00;
			first_reg <= 1'b0;
			sck_reg   <= 1'b0;
			cs_n_reg  <= 1'b1;
		end else begin
			case (state_reg)
				RLT_H_IDLE: begin
					if (go_c) begin
						cmd_reg   <= cmd_c;
						wait_reg  <= {1'b0, lat_c[15:8]} + {1'b0, lat_c[7:0]};
						lat_reg   <= lat_c[7:0];
						cnt_reg   <= 8'h00;
						cs_n_reg  <= 1'b0;
						state_reg <= RLT_H_CMD;
					end
				end
				RLT_H_CMD: begin
					if (edge_c) begin
						sck_reg <= ~sck_reg;
						if (!sck_reg)
							cnt_reg <= cnt_reg + 8'd1;
						if (!sck_reg && cnt_reg == `RLT_CMD_LAST) begin
							cnt_reg   <= cmd_reg.addr4 ? `RLT_ADDR4_BITS : `RLT_ADDR3_BITS;
							state_reg <= RLT_H_ADDR;
						end
					end
				end
				RLT_H_ADDR: begin
					if (edge_c) begin
						sck_reg <= ~sck_reg;
						if (!sck_reg || cmd_reg.ddr) begin
							cnt_reg <= cnt_reg - {5'h00, aw};
							if (cnt_reg == {5'h00, aw})
								state_reg <= RLT_H_WAIT;
						end
					end
				end
				RLT_H_WAIT: begin
					// Count mode then latency cycles on rising edges
					if (edge_c) begin
						sck_reg <= ~sck_reg;
						if (!sck_reg) begin
							wait_reg <= wait_reg - 9'd1;
							if (wait_reg <= 9'd1) begin
								first_reg <= 1'b1;
								state_reg <= RLT_H_DATA;
							end
						end
					end
				end
				RLT_H_DATA: begin
					if (edge_c) begin
						first_reg <= 1'b0;
						if (byte_c && bytes_reg == 8'd1)
							state_reg <= RLT_H_FINISH;
						else
							sck_reg <= ~sck_reg;
					end
				end
				RLT_H_FINISH: begin
					if (edge_c) begin
						sck_reg   <= 1'b0;
						cs_n_reg  <= 1'b1;
						state_reg <= RLT_H_GAP;
					end
				end
				RLT_H_GAP: begin
					if (edge_c)
						state_reg <= RLT_H_IDLE;
				end
				default: state_reg <= RLT_H_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lane drivers: outputs change mid-way through a half period
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			op_sr_reg   <= 8'h00;
			addr_sr_reg <= 32'h0000_0000;
			io_out_reg  <= 4'h0;
			io_oe_reg   <= 4'h0;
		end else if (go_c) begin
			op_sr_reg   <= opcode;
			addr_sr_reg <= cmd_c.addr4 ? addr : {addr[23:0], 8'h00};
		end else if (mid_c) begin
			io_out_reg <= 4'h0;
			io_oe_reg  <= 4'h0;
			case (state_reg)
				RLT_H_CMD: begin
					if (!sck_reg) begin
						io_out_reg <= {3'b000, op_sr_reg[7]};
						io_oe_reg  <= 4'h1;
						op_sr_reg  <= {op_sr_reg[6:0], 1'b0};
					end else begin
						io_out_reg <= io_out_reg;
						io_oe_reg  <= io_oe_reg;
					end
				end
				RLT_H_ADDR: begin
					if (!sck_reg || cmd_reg.ddr) begin
						io_out_reg  <= rlt_top_bits(addr_sr_reg, aw);
						io_oe_reg   <= rlt_lane_mask(aw);
						addr_sr_reg <= addr_sr_reg << aw;
					end else begin
						io_out_reg <= io_out_reg;
						io_oe_reg  <= io_oe_reg;
					end
				end
				// Mode bits are driven as zero, then lanes released
				RLT_H_WAIT: io_oe_reg <= (wait_reg > {1'b0, lat_reg}) ? rlt_lane_mask(aw) : 4'h0;
				default: io_oe_reg <= 4'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data assembly, most significant bit first
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_sr_reg  <= 32'h0000_0000;
			bit_reg      <= 4'h0;
			bytes_reg    <= 8'h00;
			rd_data_reg  <= 8'h00;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= byte_c;
			if (go_c) begin
				bit_reg   <= 4'h0;
				bytes_reg <= byte_count;
			end else if (sample_c) begin
				data_sr_reg <= data_next;
				bit_reg     <= byte_c ? 4'h0 : bit_reg + {1'b0, dw};
			end
			if (byte_c) begin
				rd_data_reg <= data_next[7:0];
				bytes_reg   <= bytes_reg - 8'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// User-side status
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg    <= 1'b0;
			done_reg    <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			busy_reg    <= go_c || (state_reg != RLT_H_IDLE && !(state_reg == RLT_H_GAP && edge_c));
			done_reg    <= state_reg == RLT_H_GAP && edge_c;
			refused_reg <= state_reg == RLT_H_IDLE && start && reject_c;
		end
	end

	assign link.sck      = sck_reg;
	assign link.cs_n     = cs_n_reg;
	assign link.h_io_out = io_out_reg;
	assign link.h_io_oe  = io_oe_reg;
	assign busy          = busy_reg;
	assign rd_data       = rd_data_reg;
	assign rd_valid      = rd_valid_reg;
	assign done          = done_reg;
	assign refused       = refused_reg;

endmodule

`default_nettype wire

// ### rlt_link_checker.sv
`timescale 1ns/1ps
`default_nettype none

module rlt_link_checker (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       sck,
	input wire logic       cs_n,
	input wire logic [3:0] h_io_oe,
	input wire logic [3:0] d_io_oe
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////
	// Frame opening and closing steps
	sequence frame_open;
		$fell(cs_n);
	endsequence
	sequence frame_close;
		$rose(cs_n);
	endsequence

	// Link rules on the wire
	chk_sck_idle_low: assert property (cs_n |-> !sck)
		else $error("sck high while idle");
	chk_sck_half_min: assert property ($changed(sck) |=> $stable(sck)[*5])
		else $error("sck half too short");
	chk_lane_no_clash: assert property ((h_io_oe & d_io_oe) == 4'h0)
		else $error("lane driven twice");
	chk_open_one_lane: assert property (frame_open |-> ##[1:8] h_io_oe == 4'h1)
		else $error("opcode lane wrong");
	chk_open_dev_off: assert property (frame_open |-> (d_io_oe == 4'h0)[*8])
		else $error("device drives early");
	chk_cs_gap_min: assert property (frame_close |=> cs_n[*3])
		else $error("select gap short");
	chk_dev_release: assert property (cs_n[*6] |-> d_io_oe == 4'h0)
		else $error("device not released");
	chk_dev_lane_set: assert property (d_io_oe inside {4'h0, 4'h1, 4'h3, 4'hf})
		else $error("device lane set odd");
endmodule

`default_nettype wire

// ### rlt_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rlt_link_if;
	logic       sck;
	logic       cs_n;
	logic [3:0] h_io_out;
	logic [3:0] h_io_oe;
	logic [3:0] d_io_out;
	logic [3:0] d_io_oe;
	logic [3:0] io;

	// Resolved data lanes; an undriven lane reads as pulled high
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			io[i] = h_io_oe[i] ? h_io_out[i] : (d_io_oe[i] ? d_io_out[i] : 1'b1);
		end
	end

	modport host (output sck, output cs_n, output h_io_out, output h_io_oe, input io);
	modport device (input sck, input cs_n, input io, output d_io_out, output d_io_oe);
endinterface

`default_nettype wire

// ### rlt_pkg.sv
`include "rlt_consts.svh"

package rlt_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Read command kinds, in table column order
	typedef enum logic [2:0] {
		RLT_K_READ,
		RLT_K_FAST,
		RLT_K_DOUT,
		RLT_K_QOUT,
		RLT_K_DIO,
		RLT_K_QIO
	} rlt_kind_type;

	typedef struct packed {
		logic         valid;
		logic         ddr;
		logic         addr4;
		rlt_kind_type kind;
	} rlt_cmd_type;

	typedef enum logic [2:0] {
		RLT_D_IDLE,
		RLT_D_CMD,
		RLT_D_ADDR,
		RLT_D_WAIT,
		RLT_D_DATA,
		RLT_D_IGNORE
	} rlt_dstate_type;

	typedef enum logic [2:0] {
		RLT_H_IDLE,
		RLT_H_CMD,
		RLT_H_ADDR,
		RLT_H_WAIT,
		RLT_H_DATA,
		RLT_H_FINISH,
		RLT_H_GAP
	} rlt_hstate_type;

	////////////////////////////////////////////////////////////////////////////
	// Opcode to command kind, address size and data rate
	function automatic rlt_cmd_type rlt_decode(input logic [7:0] op);
		rlt_cmd_type c;
		c = '{valid: 1'b1, ddr: 1'b0, addr4: 1'b0, kind: RLT_K_READ};
		case (op)
			`RLT_OP_READ3, `RLT_OP_READ4: c.kind = RLT_K_READ;
			`RLT_OP_FAST3, `RLT_OP_FAST4: c.kind = RLT_K_FAST;
			`RLT_OP_DOUT3, `RLT_OP_DOUT4: c.kind = RLT_K_DOUT;
			`RLT_OP_QOUT3, `RLT_OP_QOUT4: c.kind = RLT_K_QOUT;
			`RLT_OP_DIO3, `RLT_OP_DIO4: c.kind = RLT_K_DIO;
			`RLT_OP_QIO3, `RLT_OP_QIO4: c.kind = RLT_K_QIO;
			`RLT_OP_DDR_FAST3, `RLT_OP_DDR_FAST4: c.kind = RLT_K_FAST;
			`RLT_OP_DDR_DIO3, `RLT_OP_DDR_DIO4: c.kind = RLT_K_DIO;
			`RLT_OP_DDR_QIO3, `RLT_OP_DDR_QIO4: c.kind = RLT_K_QIO;
			default: c.valid = 1'b0;
		endcase
		c.ddr = op inside {`RLT_OP_DDR_FAST3, `RLT_OP_DDR_FAST4, `RLT_OP_DDR_DIO3,
			`RLT_OP_DDR_DIO4, `RLT_OP_DDR_QIO3, `RLT_OP_DDR_QIO4};
		c.addr4 = op inside {`RLT_OP_READ4, `RLT_OP_FAST4, `RLT_OP_DOUT4, `RLT_OP_QOUT4,
			`RLT_OP_DIO4, `RLT_OP_QIO4, `RLT_OP_DDR_FAST4, `RLT_OP_DDR_DIO4,
			`RLT_OP_DDR_QIO4};
		return c;
	endfunction

	// Lanes used for address and mode bits
	function automatic logic [2:0] rlt_addr_width(input rlt_kind_type k);
		return (k == RLT_K_QIO) ? 3'd4 : (k == RLT_K_DIO) ? 3'd2 : 3'd1;
	endfunction

	// Lanes used for read data
	function automatic logic [2:0] rlt_data_width(input rlt_kind_type k);
		case (k)
			RLT_K_DOUT, RLT_K_DIO: return 3'd2;
			RLT_K_QOUT, RLT_K_QIO: return 3'd4;
			default: return 3'd1;
		endcase
	endfunction

	// Output enables for a lane count
	function automatic logic [3:0] rlt_lane_mask(input logic [2:0] w);
		return (w == 3'd4) ? 4'hf : (w == 3'd2) ? 4'h3 : 4'h1;
	endfunction

	// Top bits of a word placed on the low lanes, highest bit on highest lane
	function automatic logic [3:0] rlt_top_bits(input logic [31:0] v, input logic [2:0] w);
		return (w == 3'd4) ? v[31:28] : (w == 3'd2) ? {2'b00, v[31:30]} : {3'b000, v[31]};
	endfunction

	// Shift lane bits into the bottom of a word
	function automatic logic [31:0] rlt_shift_in(input logic [31:0] v, input logic [3:0] l,
		input logic [2:0] w);
		return (w == 3'd4) ? {v[27:0], l} : (w == 3'd2) ? {v[29:0], l[1:0]} : {v[30:0], l[0]};
	endfunction

	// One byte of the fixed DDR query parameter, ffh past its end
	function automatic logic [7:0] rlt_query_byte(input logic [5:0] idx);
		logic [351:0] t;
		t = {`RLT_DDR_QUERY_HI, `RLT_DDR_QUERY_LO} << {idx, 3'b000};
		return (idx < `RLT_QUERY_LEN) ? t[351:344] : `RLT_NA;
	endfunction

	// Mode cycles (high byte) and latency cycles (low byte) of the selected row
	function automatic logic [15:0] rlt_lat_lookup(input logic ddr, input logic fast_row,
		input logic [1:0] code, input rlt_kind_type kind);
		logic [1:0]  row;
		logic [1:0]  col;
		logic [5:0]  off;
		logic [95:0] sdr;
		row = 2'd3;
		col = 2'd3;
		off = 6'h00;
		sdr = fast_row ? `RLT_SDR_ROW133 : `RLT_SDR_ROW104;
		if (ddr) begin
			case (code)
				2'b11: row = 2'd0;
				2'b00: row = 2'd1;
				2'b01: row = 2'd2;
				default: row = 2'd3;
			endcase
			case (kind)
				RLT_K_FAST: col = 2'd0;
				RLT_K_DIO: col = 2'd1;
				RLT_K_QIO: col = 2'd2;
				default: col = 2'd3;
			endcase
			off = `RLT_DDR_ROW_BASE + {1'b0, row, 3'b000} + {3'b000, col, 1'b0};
			if (col == 2'd3)
				return {`RLT_NA, `RLT_NA};
			return {rlt_query_byte(off), rlt_query_byte(off + 6'd1)};
		end
		if (code != `RLT_SDR_CODE)
			return {`RLT_NA, `RLT_NA};
		sdr = sdr << {kind, 4'h0};
		return sdr[95:80];
	endfunction

endpackage

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        clock, rst_n, start, fr, got, sck_q, dx, dref, act;
	logic        busy, rd_valid, done, refused, rd_active, cmd_refused;
	logic [7:0]  opcode, rd_data, rc;
	logic [31:0] addr;
	logic [1:0]  lc;
	int          bad_count, num_checks;

	rlt_link_if link ();
	rlt_host rlt_host_inst (.link(link), .clock(clock), .rst_n(rst_n), .start(start),
		.opcode(opcode), .addr(addr), .byte_count(8'h02), .lat_code(lc), .fast_row(fr),
		.busy(busy), .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .refused(refused));
	rlt_device rlt_device_inst (.link(link), .clock(clock), .rst_n(rst_n), .lat_code(lc),
		.fast_row(fr | dx), .rd_active(rd_active), .cmd_refused(cmd_refused));
	rlt_link_checker rlt_link_checker_inst (.clock(clock), .rst_n(rst_n), .sck(link.sck),
		.cs_n(link.cs_n), .h_io_oe(link.h_io_oe), .d_io_oe(link.d_io_oe));

	////////////////////////////////////////////////////////////////////////////
	// Serial clock rises in a frame before the device first drives
	always @(posedge clock) begin
		sck_q <= link.sck;
		if (start) begin
			rc <= 8'h00;
			{got, dref, act} <= 3'b000;
		end else if (!link.cs_n) begin
			if (|link.d_io_oe)
				got <= 1'b1;
			if (cmd_refused === 1'b1)
				dref <= 1'b1;
			if (rd_active === 1'b1)
				act <= 1'b1;
			if (link.sck && !sck_q && !got)
				rc <= rc + 8'h01;
		end
	end

	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One read of two bytes; er counts rises after the opcode
	task automatic frame(input logic [7:0] op, input logic [31:0] ad, input logic [7:0] er,
		input logic [15:0] ed, input logic rf);
		logic [15:0] d;
		logic        r;
		int          i;
		d = 16'h0000;
		r = 1'b0;
		opcode = op;
		addr = ad;
		start = 1'b1;
		@(negedge clock) start = 1'b0;
		cmp({15'h0000, busy}, {15'h0000, !rf});
		for (i = 0; i < 5000 && done !== 1'b1 && r == 1'b0; i++) begin
			if (refused === 1'b1)
				r = 1'b1;
			@(negedge clock);
			if (rd_valid === 1'b1)
				d = {d[7:0], rd_data};
		end
		if (i == 5000)
			cmp(16'h0001, 16'h0000);
		cmp({15'h0000, r}, {15'h0000, rf});
		if (!rf) begin
			cmp({8'h00, rc}, {8'h00, er + 8'h08});
			cmp(d, ed);
			cmp({14'h0000, dref, act}, {14'h0000, dx, !dx});
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Single-rate 104 MHz row
	task automatic t_sdr104();
		fr = 1'b0;
		lc = 2'b10;
		frame(8'h03, 0, 0, 0, 1'b1);
		frame(8'h0b, 0, 32, 16'h9a2a, 1'b0);
		frame(8'h3b, 0, 32, 16'h9a2a, 1'b0);
		frame(8'h6b, 0, 32, 16'h9a2a, 1'b0);
		frame(8'hbb, 0, 18, 16'h9a2a, 1'b0);
		frame(8'heb, 0, 13, 16'h9a2a, 1'b0);
		// Device alone on the 133 MHz row: it must ignore dual out
		dx = 1'b1;
		frame(8'h3b, 0, 39, 16'hffff, 1'b0);
		dx = 1'b0;
	endtask

	// Single-rate 133 MHz row
	task automatic t_sdr133();
		fr = 1'b1;
		frame(8'h0b, 4, 32, 16'h4643, 1'b0);
		frame(8'h3b, 0, 0, 0, 1'b1);
		frame(8'h6b, 0, 0, 0, 1'b1);
		frame(8'hbb, 0, 0, 0, 1'b1);
		frame(8'heb, 0, 0, 0, 1'b1);
	endtask

	// Double-rate rows for every code; all six opcodes at code 11 only
	task automatic t_ddr();
		lc = 2'b11;
		frame(8'h0d, 8'h0e, 16, 16'h0004, 1'b0);
		frame(8'hbd, 8'h0e, 10, 16'h0004, 1'b0);
		frame(8'hed, 8'h0e, 7, 16'h0004, 1'b0);
		frame(8'h0e, 2, 20, 16'h0508, 1'b0);
		frame(8'hbe, 2, 12, 16'h0508, 1'b0);
		frame(8'hee, 2, 8, 16'h0508, 1'b0);
		lc = 2'b00;
		frame(8'h0d, 8'h16, 17, 16'h0005, 1'b0);
		frame(8'hbd, 8'h16, 12, 16'h0005, 1'b0);
		frame(8'hed, 8'h16, 10, 16'h0005, 1'b0);
		lc = 2'b01;
		frame(8'h0d, 8'h1e, 18, 16'h0006, 1'b0);
		frame(8'hbd, 8'h1e, 13, 16'h0006, 1'b0);
		frame(8'hed, 8'h1e, 11, 16'h0006, 1'b0);
		lc = 2'b10;
		frame(8'h0d, 8'h26, 19, 16'h0007, 1'b0);
		frame(8'hbd, 8'h26, 14, 16'h0007, 1'b0);
		frame(8'hed, 8'h26, 12, 16'h0007, 1'b0);
		frame(8'h0e, 8'h2b, 23, 16'h08ff, 1'b0);
	endtask

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Cut a hang short
	initial begin
		#1500000;
		bad_count++;
		stop_test();
	end

	initial begin
		{start, fr, dx, opcode, addr} = '0;
		lc = 2'b10;
		bad_count = 0;
		num_checks = 0;
		rst_n = 1'b0;
		repeat (6) @(negedge clock);
		rst_n = 1'b1;
		@(negedge clock);
		t_sdr104();
		t_sdr133();
		t_ddr();
		stop_test();
	end
endmodule

`default_nettype wire
